// >>> core/pgd_pkg.sv
package pgd_pkg;
  // indexed register pointers
  localparam logic [7:0] IDX_SET_RESET_VALUE = 8'h00;
  localparam logic [7:0] IDX_SET_RESET_PLANE_ENABLE = 8'h01;
  localparam logic [7:0] IDX_COLOUR_COMPARE_VALUE = 8'h02;
  localparam logic [7:0] IDX_ROTATE_AND_FUNCTION = 8'h03;
  localparam logic [7:0] IDX_READ_PLANE_SELECT = 8'h04;
  localparam logic [7:0] IDX_READ_WRITE_MODE_CONTROL = 8'h05;
  localparam logic [7:0] IDX_MEMORY_MAP_MISC = 8'h06;
  localparam logic [7:0] IDX_COMPARE_PLANE_MASK = 8'h07;
  localparam logic [7:0] IDX_PIXEL_WRITE_MASK = 8'h08;
  localparam logic [7:0] IDX_PLANE0_LATCH_READBACK = 8'hF8;
  localparam logic [7:0] IDX_PLANE1_LATCH_READBACK = 8'hF9;
  localparam logic [7:0] IDX_PLANE2_LATCH_READBACK = 8'hFA;
  localparam logic [7:0] IDX_PLANE3_LATCH_READBACK = 8'hFB;
  // i/o ports
  localparam logic [9:0] IO_UPPER_PLANES_BIT_POSITION = 10'h3CA;
  localparam logic [9:0] IO_LOWER_PLANES_BIT_POSITION = 10'h3CC;
  localparam logic [9:0] IO_INDEXED_REGISTER_POINTER = 10'h3CE;
  localparam logic [9:0] IO_INDEXED_DATA = 10'h3CF;
  localparam logic [9:0] IO_MISC_OUTPUT = 10'h3C2;
  // field positions
  localparam int MISC_RAM_ENABLE_BIT = 1;
  localparam int MAP_LO = 2;
  localparam int FUNC_LO = 3;
  localparam int READ_MODE_BIT = 3;
  localparam logic [3:0] POINTER_INDEX_MASK = 4'hF;
  localparam logic [7:0] POINTER_READ_ONES = 8'hE0;
  localparam logic [7:0] POSITION_LOWER_RESET = 8'h00;
  localparam logic [7:0] POSITION_UPPER_RESET = 8'h01;
  // memory map window bases and sizes, cpu addr bits 19:0
  localparam logic [19:0] WIN_A0000 = 20'hA0000;
  localparam logic [19:0] WIN_B0000 = 20'hB0000;
  localparam logic [19:0] WIN_B8000 = 20'hB8000;
  localparam logic [19:0] SIZE_128K = 20'h20000;
  localparam logic [19:0] SIZE_64K = 20'h10000;
  localparam logic [19:0] SIZE_32K = 20'h08000;
  localparam int NUM_PLANES = 4;

  typedef enum logic [1:0] {
    PGD_WM_DATA,
    PGD_WM_LATCH,
    PGD_WM_COLOUR,
    PGD_WM_ILLEGAL
  } pgd_wmode_t;

  typedef enum logic [1:0] {
    PGD_FN_PASS,
    PGD_FN_AND,
    PGD_FN_OR,
    PGD_FN_XOR
  } pgd_func_t;

  typedef struct packed {
    logic [9:0] addr;
    logic [7:0] data;
    logic rd;
    logic wr;
  } pgd_io_req_t;

  typedef struct packed {
    logic [19:0] addr;
    logic [7:0] data;
    logic rd;
    logic wr;
  } pgd_mem_req_t;
endpackage

// >>> core/pgd_datapath.sv
`timescale 1ns/1ps
module pgd_datapath #(
  parameter int PLANES = 4
) (
  input wire logic clk,
  input wire logic reset,
  input wire pgd_pkg::pgd_io_req_t ioReq,
  input wire pgd_pkg::pgd_mem_req_t memReq,
  input wire logic cpuSlotNext,
  input wire logic [7:0] planeRdData [PLANES],
  output logic [7:0] cpuRdData,
  output logic cpuRdValid,
  output logic [7:0] planeWrData [PLANES],
  output logic plane0_write_strobe_n,
  output logic plane1_write_strobe_n,
  output logic plane2_write_strobe_n,
  output logic plane3_write_strobe_n,
  output logic early_cpu_slot_enable_n,
  output logic valid_read_window,
  output logic [1:0] mapSelect
);
  logic [7:0] set_reset_value;
  logic [7:0] set_reset_plane_enable;
  logic [7:0] colour_compare_value;
  logic [7:0] rotate_and_function;
  logic [7:0] read_plane_select;
  logic [7:0] read_write_mode_control;
  logic [7:0] memory_map_misc;
  logic [7:0] compare_plane_mask;
  logic [7:0] pixel_write_mask;
  logic [7:0] upper_planes_bit_position;
  logic [7:0] lower_planes_bit_position;
  logic [7:0] pointerReg;
  logic [7:0] miscOutput;
  logic [7:0] latchReg [PLANES];
  logic [7:0] cpuMapped;
  logic inWindow;
  logic [7:0] computed [PLANES];
  logic [7:0] masked [PLANES];
  logic [7:0] rotated;
  logic [7:0] compareResult;
  logic [7:0] ioReadData;
  logic [7:0] memReadData;
  logic [PLANES-1:0] next_strobe;

  // rotate right by count, bit 0 wraps into bit 7
  function automatic logic [7:0] rotr(input logic [7:0] d,
                                      input logic [2:0] n);
    logic [15:0] w;
    w = {d, d} >> n;
    return w[7:0];
  endfunction

  function automatic logic [7:0] alu(input logic [7:0] d,
                                     input logic [7:0] l,
                                     input logic [1:0] f);
    logic [7:0] r;
    r = d;
    case (f)
      2'h0: r = d;
      2'h1: r = d & l;
      2'h2: r = d | l;
      2'h3: r = d ^ l;
      default: r = d;
    endcase
    return r;
  endfunction

  // position selectors steer data bus bit pairs to planes 0/1 and 2/3
  function automatic logic [1:0] pick2(input logic [7:0] d,
                                       input logic [1:0] pos);
    return d[{pos, 1'b0} +: 2];
  endfunction

  function automatic logic inRange(input logic [19:0] a,
                                   input logic [19:0] base,
                                   input logic [19:0] size);
    return (a >= base) && (a < base + size);
  endfunction

  // latch readback needs the whole pointer, the rest the low nibble
  function automatic logic [7:0] readIndex(input logic [7:0] ptr);
    if (ptr >= pgd_pkg::IDX_PLANE0_LATCH_READBACK &&
        ptr <= pgd_pkg::IDX_PLANE3_LATCH_READBACK)
      return ptr;
    return {4'h0, ptr[3:0] & pgd_pkg::POINTER_INDEX_MASK};
  endfunction

  assign mapSelect = memory_map_misc[pgd_pkg::MAP_LO +: 2];
  assign cpuMapped = {4'h0, pick2(memReq.data,
                        upper_planes_bit_position[1:0]),
                      pick2(memReq.data, lower_planes_bit_position[1:0])};

  always_comb
  begin
    case (memory_map_misc[pgd_pkg::MAP_LO +: 2])
      2'h0: inWindow = inRange(memReq.addr, pgd_pkg::WIN_A0000,
                               pgd_pkg::SIZE_128K);
      2'h1: inWindow = inRange(memReq.addr, pgd_pkg::WIN_A0000,
                               pgd_pkg::SIZE_64K);
      2'h2: inWindow = inRange(memReq.addr, pgd_pkg::WIN_B0000,
                               pgd_pkg::SIZE_32K);
      2'h3: inWindow = inRange(memReq.addr, pgd_pkg::WIN_B8000,
                               pgd_pkg::SIZE_32K);
      default: inWindow = 1'b0;
    endcase
  end

  assign rotated = rotr(memReq.data, rotate_and_function[2:0]);

  genvar gp;
  generate
    for (gp = 0; gp < PLANES; gp++)
    begin : g_plane
      always_comb
      begin
        case (pgd_pkg::pgd_wmode_t'(read_write_mode_control[1:0]))
          pgd_pkg::PGD_WM_DATA:
            if (set_reset_plane_enable[gp])
              computed[gp] = {8{set_reset_value[gp]}};
            else
              computed[gp] = alu(rotated, latchReg[gp],
                                 rotate_and_function[pgd_pkg::FUNC_LO +: 2]);
          pgd_pkg::PGD_WM_LATCH:
            computed[gp] = latchReg[gp];
          pgd_pkg::PGD_WM_COLOUR:
            computed[gp] = alu({8{cpuMapped[gp]}}, latchReg[gp],
                               rotate_and_function[pgd_pkg::FUNC_LO +: 2]);
          default:
            computed[gp] = latchReg[gp];
        endcase
        masked[gp] = (computed[gp] & pixel_write_mask) |
                     (latchReg[gp] & ~pixel_write_mask);
      end
    end
  endgenerate

  always_comb
  begin
    for (int b = 0; b < 8; b++)
    begin
      logic m;
      m = 1'b1;
      for (int p = 0; p < PLANES; p++)
        if (compare_plane_mask[p] &&
            planeRdData[p][b] != colour_compare_value[p])
          m = 1'b0;
      compareResult[b] = m;
    end
  end

  always_comb
  begin
    if (read_write_mode_control[pgd_pkg::READ_MODE_BIT])
      memReadData = compareResult;
    else
      memReadData = planeRdData[read_plane_select[1:0]];
  end

  always_comb
  begin
    ioReadData = 8'hFF;
    case (ioReq.addr)
      pgd_pkg::IO_UPPER_PLANES_BIT_POSITION:
        ioReadData = upper_planes_bit_position;
      pgd_pkg::IO_LOWER_PLANES_BIT_POSITION:
        ioReadData = lower_planes_bit_position;
      pgd_pkg::IO_INDEXED_REGISTER_POINTER:
        ioReadData = pgd_pkg::POINTER_READ_ONES |
                     {3'h0, &pointerReg[7:5], pointerReg[3:0]};
      pgd_pkg::IO_INDEXED_DATA:
        case (readIndex(pointerReg))
          pgd_pkg::IDX_SET_RESET_VALUE: ioReadData = set_reset_value;
          pgd_pkg::IDX_SET_RESET_PLANE_ENABLE:
            ioReadData = set_reset_plane_enable;
          pgd_pkg::IDX_COLOUR_COMPARE_VALUE:
            ioReadData = colour_compare_value;
          pgd_pkg::IDX_ROTATE_AND_FUNCTION: ioReadData = rotate_and_function;
          pgd_pkg::IDX_READ_PLANE_SELECT: ioReadData = read_plane_select;
          pgd_pkg::IDX_READ_WRITE_MODE_CONTROL:
            ioReadData = read_write_mode_control;
          pgd_pkg::IDX_MEMORY_MAP_MISC: ioReadData = memory_map_misc;
          pgd_pkg::IDX_COMPARE_PLANE_MASK: ioReadData = compare_plane_mask;
          pgd_pkg::IDX_PIXEL_WRITE_MASK: ioReadData = pixel_write_mask;
          pgd_pkg::IDX_PLANE0_LATCH_READBACK: ioReadData = latchReg[0];
          pgd_pkg::IDX_PLANE1_LATCH_READBACK: ioReadData = latchReg[1];
          pgd_pkg::IDX_PLANE2_LATCH_READBACK: ioReadData = latchReg[2];
          pgd_pkg::IDX_PLANE3_LATCH_READBACK: ioReadData = latchReg[3];
          default: ioReadData = 8'hFF;
        endcase
      default: ioReadData = 8'hFF;
    endcase
  end

  // pointer port keeps the whole byte, bit 4 is rebuilt on read
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      pointerReg <= 8'h00;
    else if (ioReq.wr &&
             ioReq.addr == pgd_pkg::IO_INDEXED_REGISTER_POINTER)
      pointerReg <= ioReq.data;
  end

  // indexed data port writes, selected by the low pointer bits
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      set_reset_value <= 8'h00;
      set_reset_plane_enable <= 8'h00;
      colour_compare_value <= 8'h00;
      rotate_and_function <= 8'h00;
      read_plane_select <= 8'h00;
      read_write_mode_control <= 8'h00;
      memory_map_misc <= 8'h00;
      compare_plane_mask <= 8'h00;
      pixel_write_mask <= 8'hFF;
    end
    else if (ioReq.wr && ioReq.addr == pgd_pkg::IO_INDEXED_DATA)
      case ({4'h0, pointerReg[3:0]})
        pgd_pkg::IDX_SET_RESET_VALUE: set_reset_value <= ioReq.data;
        pgd_pkg::IDX_SET_RESET_PLANE_ENABLE:
          set_reset_plane_enable <= ioReq.data;
        pgd_pkg::IDX_COLOUR_COMPARE_VALUE: colour_compare_value <= ioReq.data;
        pgd_pkg::IDX_ROTATE_AND_FUNCTION: rotate_and_function <= ioReq.data;
        pgd_pkg::IDX_READ_PLANE_SELECT: read_plane_select <= ioReq.data;
        pgd_pkg::IDX_READ_WRITE_MODE_CONTROL:
          read_write_mode_control <= ioReq.data;
        pgd_pkg::IDX_MEMORY_MAP_MISC: memory_map_misc <= ioReq.data;
        pgd_pkg::IDX_COMPARE_PLANE_MASK: compare_plane_mask <= ioReq.data;
        pgd_pkg::IDX_PIXEL_WRITE_MASK: pixel_write_mask <= ioReq.data;
        default: ;
      endcase
  end

  // direct ports: position selectors and misc output (ram enable)
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      lower_planes_bit_position <= pgd_pkg::POSITION_LOWER_RESET;
      upper_planes_bit_position <= pgd_pkg::POSITION_UPPER_RESET;
      miscOutput <= 8'h00;
    end
    else if (ioReq.wr)
    begin
      if (ioReq.addr == pgd_pkg::IO_LOWER_PLANES_BIT_POSITION)
        lower_planes_bit_position <= ioReq.data;
      if (ioReq.addr == pgd_pkg::IO_UPPER_PLANES_BIT_POSITION)
        upper_planes_bit_position <= ioReq.data;
      if (ioReq.addr == pgd_pkg::IO_MISC_OUTPUT)
        miscOutput <= ioReq.data;
    end
  end

  // latches reload from the planes on every display memory read inside the valid read window
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      for (int p = 0; p < PLANES; p++)
        latchReg[p] <= 8'h00;
    else if (memReq.rd && valid_read_window)
      for (int p = 0; p < PLANES; p++)
        latchReg[p] <= planeRdData[p];
  end

  // strobes only for write modes 0..2, inside the window
  assign next_strobe = {PLANES{memReq.wr && valid_read_window &&
                        read_write_mode_control[1:0] != 2'h3}};

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      plane0_write_strobe_n <= 1'b1;
      plane1_write_strobe_n <= 1'b1;
      plane2_write_strobe_n <= 1'b1;
      plane3_write_strobe_n <= 1'b1;
      for (int p = 0; p < PLANES; p++)
        planeWrData[p] <= 8'h00;
    end
    else
    begin
      plane0_write_strobe_n <= ~next_strobe[0];
      plane1_write_strobe_n <= ~next_strobe[1];
      plane2_write_strobe_n <= ~next_strobe[2];
      plane3_write_strobe_n <= ~next_strobe[3];
      for (int p = 0; p < PLANES; p++)
        planeWrData[p] <= masked[p];
    end
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      valid_read_window <= 1'b0;
    else
      valid_read_window <= miscOutput[pgd_pkg::MISC_RAM_ENABLE_BIT] &&
                           inWindow;
  end

  // slot marker arrives one clock before the cpu slot
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      early_cpu_slot_enable_n <= 1'b1;
    else
      early_cpu_slot_enable_n <= ~cpuSlotNext;
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      cpuRdData <= 8'h00;
      cpuRdValid <= 1'b0;
    end
    else
    begin
      cpuRdValid <= ioReq.rd || memReq.rd;
      cpuRdData <= memReq.rd ? memReadData : ioReadData;
    end
  end

  property p_wm3_no_strobe;
    @(posedge clk) disable iff (reset)
      (read_write_mode_control[1:0] == 2'h3) |=> plane0_write_strobe_n;
  endproperty
  a_wm3_no_strobe: assert property (p_wm3_no_strobe)
    else $error("strobe in illegal write mode");

  property p_strobe_cause;
    @(posedge clk) disable iff (reset)
      !plane2_write_strobe_n |-> $past(memReq.wr);
  endproperty
  a_strobe_cause: assert property (p_strobe_cause)
    else $error("strobe without write");

  property p_early;
    @(posedge clk) disable iff (reset)
      cpuSlotNext |=> !early_cpu_slot_enable_n;
  endproperty
  a_early: assert property (p_early)
    else $error("early enable late");

  property p_window;
    @(posedge clk) disable iff (reset)
      valid_read_window |-> $past(miscOutput[1]);
  endproperty
  a_window: assert property (p_window)
    else $error("window without ram enable");

  property p_mask;
    @(posedge clk) disable iff (reset)
      (pixel_write_mask == 8'h00) |=> planeWrData[0] == $past(latchReg[0]);
  endproperty
  a_mask: assert property (p_mask)
    else $error("masked bits changed");

  property p_ptr;
    @(posedge clk) disable iff (reset)
      (ioReq.rd && ioReq.addr == pgd_pkg::IO_INDEXED_REGISTER_POINTER)
        |=> cpuRdData[7:5] == 3'h7;
  endproperty
  a_ptr: assert property (p_ptr)
    else $error("pointer upper bits not ones");

  property p_latch;
    @(posedge clk) disable iff (reset)
      (memReq.rd && valid_read_window)
        |=> latchReg[1] == $past(planeRdData[1]);
  endproperty
  a_latch: assert property (p_latch)
    else $error("latch not reloaded");

  property p_srset;
    @(posedge clk) disable iff (reset)
      (read_write_mode_control[1:0] == 2'h0 && set_reset_plane_enable[3] &&
       pixel_write_mask == 8'hFF)
        |=> planeWrData[3] == {8{$past(set_reset_value[3])}};
  endproperty
  a_srset: assert property (p_srset)
    else $error("set reset not replicated");
endmodule

// >>> tb/pgd_plane_model.sv
`timescale 1ns/1ps
// four byte-wide display planes, 16 bytes each, indexed by address bits 3:0
module pgd_plane_model (
  input wire logic clk,
  input wire logic [19:0] memAddr,
  input wire logic [7:0] planeWrData [4],
  input wire logic [3:0] strobeN,
  output logic [7:0] planeRdData [4]
);
  logic [7:0] mem [4][16];

  initial
  begin
    for (int i = 0; i < 4; i++)
      for (int j = 0; j < 16; j++)
        mem[i][j] = 8'h00;
  end

  // a plane takes its byte only on its own low strobe
  always @(posedge clk)
    for (int i = 0; i < 4; i++)
      if (strobeN[i] === 1'b0)
        mem[i][memAddr[3:0]] <= planeWrData[i];

  always_comb
    for (int i = 0; i < 4; i++)
      planeRdData[i] = mem[i][memAddr[3:0]];
endmodule

// >>> tb/planar_graphics_datapath_bench.sv
`timescale 1ns/1ps
module planar_graphics_datapath_bench;
  logic clk;
  logic reset;
  pgd_pkg::pgd_io_req_t ioReq;
  pgd_pkg::pgd_mem_req_t memReq;
  logic cpuSlotNext;
  logic [7:0] planeRdData [4];
  logic [7:0] planeWrData [4];
  logic [7:0] cpuRdData;
  logic cpuRdValid;
  logic [3:0] strobeN;
  logic earlyN;
  logic window;
  logic [1:0] mapSel;
  logic [7:0] got;
  int n_mismatch;
  int checks;
  logic [19:0] base [4];
  logic [19:0] size [4];
  logic [7:0] fnExp [4];

  pgd_datapath uut (
    .clk(clk),
    .reset(reset),
    .ioReq(ioReq),
    .memReq(memReq),
    .cpuSlotNext(cpuSlotNext),
    .planeRdData(planeRdData),
    .cpuRdData(cpuRdData),
    .cpuRdValid(cpuRdValid),
    .planeWrData(planeWrData),
    .plane0_write_strobe_n(strobeN[0]),
    .plane1_write_strobe_n(strobeN[1]),
    .plane2_write_strobe_n(strobeN[2]),
    .plane3_write_strobe_n(strobeN[3]),
    .early_cpu_slot_enable_n(earlyN),
    .valid_read_window(window),
    .mapSelect(mapSel)
  );

  pgd_plane_model planes (
    .clk(clk),
    .memAddr(memReq.addr),
    .planeWrData(planeWrData),
    .strobeN(strobeN),
    .planeRdData(planeRdData)
  );

  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task report_and_stop;
    $display("comparisons %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    checks++;
    if (g !== e)
    begin
      $display("wrong value %s expected %h seen %h", nm, e, g);
      n_mismatch++;
    end
  endtask

  // one i/o or memory cycle; memory address is set two cycles ahead
  task acc(input bit m, input bit w, input logic [19:0] a,
           input logic [7:0] d);
    got = 8'hXX;
    if (m)
    begin
      memReq <= '{addr: a, data: d, rd: 1'b0, wr: 1'b0};
      repeat (2) @(posedge clk);
      memReq.rd <= ~w;
      memReq.wr <= w;
    end
    else
      ioReq <= '{addr: a[9:0], data: d, rd: ~w, wr: w};
    @(posedge clk);
    memReq.rd <= 1'b0;
    memReq.wr <= 1'b0;
    ioReq.rd <= 1'b0;
    ioReq.wr <= 1'b0;
    repeat (3)
    begin
      @(negedge clk);
      if (cpuRdValid === 1'b1)
        got = cpuRdData;
      @(posedge clk);
    end
  endtask

  task rd(input bit m, input logic [19:0] a, input logic [7:0] e,
          input string nm);
    acc(m, 1'b0, a, 8'h00);
    chk(nm, e, got);
  endtask

  task gw(input logic [7:0] i, input logic [7:0] v);
    acc(1'b0, 1'b1, {10'h000, pgd_pkg::IO_INDEXED_REGISTER_POINTER}, i);
    acc(1'b0, 1'b1, {10'h000, pgd_pkg::IO_INDEXED_DATA}, v);
  endtask

  // read all four planes of one byte in read mode 0, {p3,p2,p1,p0}
  task planeChk(input logic [19:0] a, input logic [31:0] e);
    for (int p = 0; p < 4; p++)
    begin
      gw(8'h04, 8'(p));
      rd(1'b1, a, e[p*8 +: 8], "plane byte");
    end
  endtask

  task winChk(input logic [19:0] a, input logic e);
    memReq.addr <= a;
    repeat (3) @(posedge clk);
    @(negedge clk);
    chk("read window", {7'h00, e}, {7'h00, window});
    @(posedge clk);
  endtask

  task done(input string nm);
    $display("test %s done", nm);
  endtask

  initial
  begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    report_and_stop;
  end

  initial
  begin
    reset = 1'b1;
    ioReq = '0;
    memReq = '0;
    cpuSlotNext = 1'b0;
    base = '{20'hA0000, 20'hA0000, 20'hB0000, 20'hB8000};
    size = '{20'h20000, 20'h10000, 20'h08000, 20'h08000};
    fnExp = '{8'h3C, 8'h30, 8'hFC, 8'hCC};
    repeat (16) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    acc(1'b0, 1'b1, 20'h003CE, 8'hF3);
    rd(1'b0, 20'h003CE, 8'hF3, "pointer");
    acc(1'b0, 1'b1, 20'h003CE, 8'hD3);
    rd(1'b0, 20'h003CE, 8'hE3, "pointer");
    acc(1'b0, 1'b1, 20'h003CE, 8'h03);
    rd(1'b0, 20'h003CE, 8'hE3, "pointer");
    rd(1'b0, 20'h003CC, 8'h00, "lower position");
    rd(1'b0, 20'h003CA, 8'h01, "upper position");
    for (int i = 0; i < 9; i++)
    begin
      acc(1'b0, 1'b1, 20'h003CE, 8'(i));
      rd(1'b0, 20'h003CF, (i == 8) ? 8'hFF : 8'h00, "reset value");
      acc(1'b0, 1'b1, 20'h003CF, 8'(i * 17) ^ 8'h5A);
      acc(1'b0, 1'b1, 20'h003CE, 8'(i) | 8'hE0);
      rd(1'b0, 20'h003CF, 8'(i * 17) ^ 8'h5A, "register");
    end
    acc(1'b0, 1'b1, 20'h003CE, 8'h0C);
    rd(1'b0, 20'h003CF, 8'hFF, "unmapped index");
    acc(1'b0, 1'b1, 20'h003CC, 8'h00);
    acc(1'b0, 1'b1, 20'h003CA, 8'h01);
    done("registers");
    acc(1'b0, 1'b1, 20'h003C2, 8'h02);
    for (int m = 0; m < 4; m++)
    begin
      gw(8'h06, 8'(m << 2));
      chk("map select", 8'(m), {6'h00, mapSel});
      winChk(base[m], 1'b1);
      winChk(base[m] - 20'h1, 1'b0);
      winChk(base[m] + size[m] - 20'h1, 1'b1);
      winChk(base[m] + size[m], 1'b0);
    end
    acc(1'b0, 1'b1, 20'h003C2, 8'h00);
    winChk(20'hA0000, 1'b0);
    acc(1'b0, 1'b1, 20'h003C2, 8'h02);
    done("window");
    gw(8'h06, 8'h04);
    gw(8'h05, 8'h00);
    gw(8'h03, 8'h00);
    gw(8'h08, 8'hFF);
    gw(8'h01, 8'h0F);
    gw(8'h00, 8'h05);
    acc(1'b1, 1'b1, 20'hA0000, 8'h00);
    gw(8'h01, 8'h00);
    planeChk(20'hA0000, 32'h00FF00FF);
    gw(8'h03, 8'h03);
    acc(1'b1, 1'b1, 20'hA0005, 8'h01);
    planeChk(20'hA0005, 32'h20202020);
    gw(8'h03, 8'h00);
    acc(1'b1, 1'b1, 20'hA0001, 8'hF0);
    for (int f = 0; f < 4; f++)
    begin
      rd(1'b1, 20'hA0001, 8'hF0, "latch source");
      gw(8'h03, 8'(f << 3));
      acc(1'b1, 1'b1, 20'hA0002, 8'h3C);
      gw(8'h03, 8'h00);
      gw(8'h04, 8'h01);
      rd(1'b1, 20'hA0002, fnExp[f], "function");
    end
    rd(1'b1, 20'hA0001, 8'hF0, "latch source");
    gw(8'h08, 8'h0F);
    acc(1'b1, 1'b1, 20'hA0002, 8'h00);
    gw(8'h08, 8'hFF);
    planeChk(20'hA0002, 32'hF0F0F0F0);
    done("write mode 0");
    rd(1'b1, 20'hA0000, 8'h00, "latch source");
    gw(8'h05, 8'h01);
    acc(1'b1, 1'b1, 20'hA0003, 8'h3C);
    planeChk(20'hA0003, 32'h00FF00FF);
    rd(1'b1, 20'hA0001, 8'hF0, "latch source");
    gw(8'h08, 8'h0F);
    gw(8'h05, 8'h02);
    acc(1'b1, 1'b1, 20'hA0004, 8'h0A);
    gw(8'h08, 8'hFF);
    planeChk(20'hA0004, 32'hFFF0FFF0);
    gw(8'h05, 8'h03);
    acc(1'b1, 1'b1, 20'hA0004, 8'h55);
    planeChk(20'hA0004, 32'hFFF0FFF0);
    gw(8'h05, 8'h00);
    acc(1'b1, 1'b1, 20'hC0000, 8'h77);
    acc(1'b0, 1'b1, 20'h003C2, 8'h00);
    acc(1'b1, 1'b1, 20'hA0000, 8'h77);
    acc(1'b0, 1'b1, 20'h003C2, 8'h02);
    planeChk(20'hA0000, 32'h00FF00FF);
    for (int p = 0; p < 4; p++)
    begin
      acc(1'b0, 1'b1, 20'h003CE, 8'hF8 + 8'(p));
      rd(1'b0, 20'h003CF, (p % 2 == 0) ? 8'hFF : 8'h00, "latch");
    end
    done("write modes");
    gw(8'h02, 8'h05);
    gw(8'h07, 8'h0F);
    gw(8'h05, 8'h08);
    rd(1'b1, 20'hA0000, 8'hFF, "compare");
    gw(8'h02, 8'h03);
    rd(1'b1, 20'hA0000, 8'h00, "compare");
    gw(8'h07, 8'h01);
    rd(1'b1, 20'hA0000, 8'hFF, "compare");
    gw(8'h04, 8'h03);
    rd(1'b1, 20'hA0000, 8'hFF, "compare");
    gw(8'h05, 8'h00);
    done("read modes");
    cpuSlotNext <= 1'b1;
    @(posedge clk);
    cpuSlotNext <= 1'b0;
    @(negedge clk);
    chk("early enable", 8'h00, {7'h00, earlyN});
    @(posedge clk);
    @(negedge clk);
    chk("early enable", 8'h01, {7'h00, earlyN});
    done("early enable");
    report_and_stop;
  end
endmodule
